// ### design/ambient_calibration_control.sv
// Ambient calibration control registers and the sequence-level controls they steer
module ambient_calibration_control (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire ambient_cal_pkg::reg_req_t reg_req,
    input wire logic [1:0] power_mode,
    input wire logic [3:0] stage_count,
    input wire logic [3:0] stage_index,
    input wire logic stage_done,
    input wire logic sample_tick,
    input wire logic proximity,
    output logic [15:0] reg_rdata,
    output logic [11:0] cal_update,
    output logic forced_recal,
    output logic sequence_restart,
    output logic fast_fifo_admit,
    output logic average_take,
    output logic cal_suspended,
    output logic power_drop
);
    function automatic logic [3:0] clamp_stage(input logic [3:0] v);
        clamp_stage = (v > ambient_cal_pkg::LAST_STAGE) ? ambient_cal_pkg::LAST_STAGE : v;
    endfunction

    function automatic ambient_cal_pkg::power_mode_t mode_of(input logic [1:0] pm);
        mode_of = ambient_cal_pkg::power_mode_t'(pm);
    endfunction

    logic [15:0] cal_en_q, cal_en_d;
    logic [15:0] comp0_q, comp0_d;
    logic [3:0] ff_cnt_q, ff_cnt_d;
    logic [5:0] avg_cnt_q, avg_cnt_d;
    logic [8:0] susp_q, susp_d;
    logic [8:0] tmo_q, tmo_d;
    logic [15:0] rdata_d;
    logic [11:0] cal_upd_d;
    logic restart_d, admit_d, take_d, drop_d;

    wire is_full = (mode_of(power_mode) == ambient_cal_pkg::MODE_FULL);
    wire is_low = (mode_of(power_mode) == ambient_cal_pkg::MODE_LOW);
    wire is_on = is_full | is_low;

    wire wr_cal = reg_req.wr & (reg_req.addr == ambient_cal_pkg::CAL_EN_ADDR);
    wire wr_comp = reg_req.wr & (reg_req.addr == ambient_cal_pkg::COMP0_ADDR);
    wire restart_req = wr_comp & reg_req.wdata[ambient_cal_pkg::RESTART_BIT];

    // Restart bit is never stored so software always reads it back as zero
    assign cal_en_d = wr_cal ? reg_req.wdata : cal_en_q;
    assign comp0_d = wr_comp ? (reg_req.wdata & ambient_cal_pkg::STORED_MASK) : comp0_q;

    wire [3:0] ff_limit = clamp_stage(comp0_q[ambient_cal_pkg::FF_SKIP_LSB +: 4]);
    wire [3:0] fp_prox = comp0_q[ambient_cal_pkg::FP_PROX_LSB +: 4];
    wire [3:0] lp_prox = comp0_q[ambient_cal_pkg::LP_PROX_LSB +: 4];
    wire [1:0] tmo_code = comp0_q[ambient_cal_pkg::TMO_LSB +: 2];
    wire [1:0] fp_skip_code = cal_en_q[ambient_cal_pkg::FP_SKIP_LSB +: 2];
    wire [1:0] lp_skip_code = cal_en_q[ambient_cal_pkg::LP_SKIP_LSB +: 2];

    wire seq_end = is_on & stage_done & (stage_index == clamp_stage(stage_count));

    // Fast filter: discard ff_limit sequences, then admit one
    wire admit_now = seq_end & (ff_cnt_q >= ff_limit);
    assign admit_d = admit_now & ~restart_req;
    assign ff_cnt_d = restart_req ? 4'h0 : (admit_now ? 4'h0 : (seq_end ? ff_cnt_q + 4'h1 : ff_cnt_q));

    // Averaging path sample skip
    wire [5:0] fp_skip = 6'((ambient_cal_pkg::FP_SKIP_BASE << fp_skip_code) - 6'h01);
    wire [5:0] lp_skip = {4'h0, lp_skip_code};
    wire [5:0] avg_skip = is_full ? fp_skip : lp_skip;
    wire take_now = is_on & sample_tick & (avg_cnt_q >= avg_skip);
    assign take_d = take_now & ~restart_req;
    assign avg_cnt_d = (restart_req | take_now) ? 6'h00 :
                       ((is_on & sample_tick) ? avg_cnt_q + 6'h01 : avg_cnt_q);

    // Suspension reloads while proximity holds, so the period runs from its release
    // Operands are widened first: a 5-bit product would wrap for FP counts above one and LP counts above seven
    wire [8:0] fp_susp = {5'h00, fp_prox} * {4'h0, ambient_cal_pkg::FP_PROX_MULT};
    wire [8:0] lp_susp = {5'h00, lp_prox} * {4'h0, ambient_cal_pkg::LP_PROX_MULT};
    assign susp_d = (proximity & is_full) ? fp_susp :
                    (proximity & is_low) ? lp_susp :
                    ((seq_end & (susp_q != 9'h000)) ? susp_q - 9'h001 : susp_q);
    wire suspended = proximity | (susp_q != 9'h000);

    // Timeout in sequences: FP count x 16 x (5..8)/4
    // Quarter factor times sixteen folds to factor times four; the largest limit is 480
    wire [3:0] tmo_quarters = ambient_cal_pkg::TMO_BASE_QUARTERS + {2'b00, tmo_code};
    wire [4:0] tmo_scale = ambient_cal_pkg::FP_PROX_MULT >> 2;
    wire [8:0] tmo_limit = {5'h00, fp_prox} * {5'h00, tmo_quarters}
                           * {4'h0, tmo_scale};
    wire tmo_hit = is_full & ~proximity & seq_end & (tmo_q + 9'h001 == tmo_limit);
    assign drop_d = tmo_hit;
    assign tmo_d = (~is_full | proximity | restart_req) ? 9'h000 :
                   ((seq_end & (tmo_q < tmo_limit)) ? tmo_q + 9'h001 : tmo_q);

    // A disabled stage gets no update strobe, so its stored values stay put
    genvar gi;
    generate
        for (gi = 0; gi < ambient_cal_pkg::STAGES; gi++) begin : g_stage
            assign cal_upd_d[gi] = is_on & stage_done & (stage_index == 4'(gi))
                                   & cal_en_q[gi]
                                   & (comp0_q[ambient_cal_pkg::FORCE_BIT] | ~suspended);
        end
    endgenerate

    assign restart_d = restart_req;
    assign rdata_d = ~reg_req.rd ? reg_rdata :
                     (reg_req.addr == ambient_cal_pkg::CAL_EN_ADDR) ? cal_en_q :
                     (reg_req.addr == ambient_cal_pkg::COMP0_ADDR) ? comp0_q : 16'h0000;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_en_q <= ambient_cal_pkg::CAL_EN_RESET;
            comp0_q <= ambient_cal_pkg::COMP0_RESET;
            ff_cnt_q <= 4'h0;
            avg_cnt_q <= 6'h00;
            susp_q <= 9'h000;
            tmo_q <= 9'h000;
            reg_rdata <= 16'h0000;
            cal_update <= 12'h000;
            forced_recal <= 1'b0;
            sequence_restart <= 1'b0;
            fast_fifo_admit <= 1'b0;
            average_take <= 1'b0;
            cal_suspended <= 1'b0;
            power_drop <= 1'b0;
        end else begin
            cal_en_q <= cal_en_d;
            comp0_q <= comp0_d;
            ff_cnt_q <= ff_cnt_d;
            avg_cnt_q <= avg_cnt_d;
            susp_q <= susp_d;
            tmo_q <= tmo_d;
            reg_rdata <= rdata_d;
            cal_update <= cal_upd_d;
            forced_recal <= comp0_d[ambient_cal_pkg::FORCE_BIT];
            sequence_restart <= restart_d;
            fast_fifo_admit <= admit_d;
            average_take <= take_d;
            cal_suspended <= (susp_d != 9'h000) | proximity;
            power_drop <= drop_d;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    cal_gate_a: assert property (stage_done && stage_index < 4'hc && !cal_en_q[stage_index]
        |=> cal_update == 12'h000) else $error("disabled stage updated");
    cal_en_a: assert property (wr_cal |=> cal_en_q == $past(reg_req.wdata))
        else $error("enable not stored");
    restart_pulse_a: assert property (restart_req |=> sequence_restart
        ##0 !comp0_q[ambient_cal_pkg::RESTART_BIT] ##1 !sequence_restart)
        else $error("restart not one pulse");
    shutdown_quiet_a: assert property (!is_on |=> cal_update == 12'h000 && !fast_fifo_admit
        && !average_take) else $error("activity in shutdown");
    ff_admit_a: assert property (fast_fifo_admit |-> $past(ff_cnt_q) >= $past(ff_limit))
        else $error("fast filter admitted early");
    fp_skip_a: assert property (average_take && $past(is_full)
        |-> $past(avg_cnt_q) == $past(fp_skip)) else $error("full power skip wrong");
    lp_skip_a: assert property (average_take && $past(is_low)
        |-> $past(avg_cnt_q) == $past(lp_skip)) else $error("low power skip wrong");
    fp_susp_a: assert property (proximity && is_full |=> susp_q == ({5'h00, $past(fp_prox)} << 4))
        else $error("full power suspend length wrong");
    lp_susp_a: assert property (proximity && is_low |=> susp_q == ({5'h00, $past(lp_prox)} << 2))
        else $error("low power suspend length wrong");
    forced_a: assert property (forced_recal && stage_done && is_on && stage_index < 4'hc
        && cal_en_q[stage_index] |=> cal_update != 12'h000) else $error("forced cal ignored");
    timeout_a: assert property (power_drop |-> $past(tmo_q) + 9'h001 == $past(tmo_limit)
        && $past(is_full)) else $error("timeout at wrong count");
    seq_len_a: assert property (fast_fifo_admit |-> $past(stage_index)
        == clamp_stage($past(stage_count))) else $error("sequence end wrong");


    // Register read-back and out-of-range stage guards
    rd_cal_a: assert property (reg_req.rd && reg_req.addr == ambient_cal_pkg::CAL_EN_ADDR
        |=> reg_rdata == $past(cal_en_q))
        else $error("enable read back wrong");
    stage_range_a: assert property (stage_done && stage_index > ambient_cal_pkg::LAST_STAGE
        |=> cal_update == 12'h000)
        else $error("update for a stage that does not exist");

    // The forced bit is a plain level that follows the stored register bit
    forced_level_a: assert property (forced_recal == comp0_q[ambient_cal_pkg::FORCE_BIT])
        else $error("forced level mismatch");

    // Restart clears both skip counters and swallows a coinciding strobe
    restart_clear_a: assert property (restart_req
        |=> ff_cnt_q == 4'h0 && avg_cnt_q == 6'h00)
        else $error("restart left counters running");
    restart_quiet_a: assert property (restart_req
        |=> !fast_fifo_admit && !average_take)
        else $error("strobe during restart");

    // Suspension flag only stands while proximity or the countdown is live
    susp_level_a: assert property (cal_suspended
        |-> $past(proximity) || susp_q != 9'h000)
        else $error("suspended without cause");

    // The timeout fires once per idle stretch and only in full power
    drop_once_a: assert property (power_drop
        |=> !power_drop)
        else $error("timeout pulse repeated");
    drop_mode_a: assert property (!is_full
        |=> !power_drop)
        else $error("timeout outside full power");

    admit_c: cover property (fast_fifo_admit ##[1:40] fast_fifo_admit);
    forced_c: cover property (forced_recal && cal_update != 12'h000);
    restart_c: cover property (restart_req ##1 sequence_restart);
    drop_c: cover property (power_drop);
    suspend_c: cover property (cal_suspended ##1 !cal_suspended);
endmodule

// ### design/ambient_cal_pkg.sv
// Constants, field layout and carrier types for the ambient calibration control bank
package ambient_cal_pkg;
    localparam logic [9:0] CAL_EN_ADDR = 10'h001;
    localparam logic [9:0] COMP0_ADDR = 10'h002;
    localparam logic [15:0] CAL_EN_RESET = 16'h0000;
    localparam logic [15:0] COMP0_RESET = 16'h0ff0;
    localparam int STAGES = 12;
    localparam logic [3:0] LAST_STAGE = 4'hb;
    // Field positions
    localparam int FF_SKIP_LSB = 0;
    localparam int FP_PROX_LSB = 4;
    localparam int LP_PROX_LSB = 8;
    localparam int TMO_LSB = 12;
    localparam int FORCE_BIT = 14;
    localparam int RESTART_BIT = 15;
    localparam int FP_SKIP_LSB = 12;
    localparam int LP_SKIP_LSB = 14;
    // Multipliers, in conversion sequences
    localparam logic [4:0] FP_PROX_MULT = 5'h10;
    localparam logic [4:0] LP_PROX_MULT = 5'h04;
    // Timeout factor in quarters: 1.25 = 5/4 up to 2.00 = 8/4
    localparam logic [3:0] TMO_BASE_QUARTERS = 4'h5;
    localparam logic [5:0] FP_SKIP_BASE = 6'h04;
    localparam logic [15:0] STORED_MASK = 16'h7fff;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        MODE_FULL = 2'b00,
        MODE_OFF_A = 2'b01,
        MODE_LOW = 2'b10,
        MODE_OFF_B = 2'b11
    } power_mode_t;
endpackage

// ### tb/testbench.sv
// Register and sequence-control checks for the ambient calibration control bank
`define check(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0;
    logic arst_n = 0;
    ambient_cal_pkg::reg_req_t reg_req = '0;
    logic [1:0] power_mode = 2'h0;
    logic [3:0] stage_count = 4'h0;
    logic [3:0] stage_index = 4'h0;
    logic stage_done = 0;
    logic sample_tick = 0;
    logic proximity = 0;
    logic [15:0] reg_rdata, rd_val;
    logic [11:0] cal_update;
    logic forced_recal, sequence_restart, fast_fifo_admit, average_take;
    logic cal_suspended, power_drop;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int takes;
    ambient_calibration_control DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_req(reg_req),
        .power_mode(power_mode), .stage_count(stage_count), .stage_index(stage_index),
        .stage_done(stage_done), .sample_tick(sample_tick), .proximity(proximity),
        .reg_rdata(reg_rdata), .cal_update(cal_update), .forced_recal(forced_recal),
        .sequence_restart(sequence_restart), .fast_fifo_admit(fast_fifo_admit),
        .average_take(average_take), .cal_suspended(cal_suspended), .power_drop(power_drop));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Every task except give_verdict starts 1 ns after a rising edge and returns 1 ns after the last edge it waits for
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        reg_req.wr = 1; reg_req.addr = a; reg_req.wdata = d;
        @(posedge ref_clk); #1 reg_req.wr = 0;
    endtask
    task automatic rd(input logic [9:0] a);
        reg_req.rd = 1; reg_req.addr = a;
        @(posedge ref_clk); #1 reg_req.rd = 0; rd_val = reg_rdata;
    endtask
    task automatic stage(input logic [3:0] idx);
        stage_done = 1; stage_index = idx;
        @(posedge ref_clk); #1 stage_done = 0;
    endtask
    // Counts takes over eight samples, so the answer does not depend on the skip phase
    task automatic ticks();
        takes = 0;
        repeat (8) begin
            sample_tick = 1; @(posedge ref_clk); #1 sample_tick = 0;
            takes += int'(average_take === 1'b1);
            @(posedge ref_clk); #1;
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        forever begin
            @(posedge ref_clk); cycles++;
            if (cycles == 3000) begin failures++; $display("Error at %0t: timeout", $time);
                give_verdict(); end
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 arst_n = 1;
        @(posedge ref_clk); #1;
        rd(10'h001); `check(rd_val, 16'h0000)
        rd(10'h002); `check(rd_val, 16'h0ff0)
        wr(10'h003, 16'hffff); rd(10'h003); `check(rd_val, 16'h0000)
        $display("test reset values done");
        // Stage 0 enabled, full power skip code 00, low power skip code 01
        wr(10'h001, 16'h4001); rd(10'h001); `check(rd_val, 16'h4001)
        wr(10'h002, 16'hc001); `check(sequence_restart, 1'b1)
        @(posedge ref_clk); #1 `check(sequence_restart, 1'b0)
        `check(forced_recal, 1'b1)
        rd(10'h002); `check(rd_val, 16'h4001)
        $display("test restart and force done");
        stage(4'h1); `check(cal_update, 12'h000)
        stage(4'h0); `check(fast_fifo_admit, 1'b0)
        `check(cal_update, 12'h001)
        stage(4'h0); `check(fast_fifo_admit, 1'b1)
        $display("test fast filter done");
        ticks(); `check(takes, 2)
        power_mode = 2'h2;
        ticks(); `check(takes, 4)
        $display("test averaging done");
        // FP count 1: suspension 16 sequences, timeout 1 x 16 x 5/4 = 20 sequences
        power_mode = 2'h0;
        wr(10'h002, 16'h0011); rd(10'h002); `check(rd_val, 16'h0011)
        proximity = 1;
        @(posedge ref_clk); #1 proximity = 0;
        `check(cal_suspended, 1'b1)
        for (int i = 1; i <= 20; i++) begin
            stage(4'h0);
            `check(cal_suspended, 1'(i < 16))
            `check(cal_update, 12'(i > 16))
            `check(power_drop, 1'(i == 20))
        end
        $display("test suspension and timeout done");
        power_mode = 2'h1;
        stage(4'h0); `check(cal_update, 12'h000)
        stage(4'h0); `check(fast_fifo_admit, 1'b0)
        ticks(); `check(takes, 0)
        $display("test shutdown done");
        give_verdict();
    end
endmodule
